// File: design/strap_cfg_pkg.sv
package strap_cfg_pkg;

   // boot select codes
   localparam logic [1:0] BOOT_ROM_NAND = 2'h0;
   localparam logic [1:0] BOOT_EXT_MEM  = 2'h1;
   localparam logic [1:0] BOOT_RSVD     = 2'h2;
   localparam logic [1:0] BOOT_ROM_UART = 2'h3;

   // defaults after reset, matching the internal pulls
   localparam logic [1:0] BOOT_SEL_RST   = 2'h0;
   localparam logic       CS_WIDTH_RST   = 1'h0;
   localparam logic [4:0] ADDR_WIDTH_RST = 5'h00;
   localparam logic       DSP_BOOT_RST   = 1'h0;

   // fetch targets
   localparam logic [31:0] ROM_ENTRY_ADDR  = 32'h0000_4000;
   localparam logic [31:0] EXT_ENTRY_ADDR  = 32'h0200_0000;
   localparam logic [31:0] DSP_BOOT_ADDR   = 32'h4220_0000;
   localparam logic [31:0] DSP_BOOT_HOST   = 32'h0220_0000;

   // wait-state reset values (slowest access)
   localparam logic [4:0] SETUP_CYC_RST  = 5'h10;
   localparam logic [6:0] STROBE_CYC_RST = 7'h40;
   localparam logic [3:0] HOLD_CYC_RST   = 4'h8;

   localparam int NUM_ADDR_PINS = 22;
   localparam int NUM_CS        = 4;

   localparam logic [NUM_ADDR_PINS-1:0] ADDR_GP_RST = 22'h3FFFF9;

   typedef struct packed {
      logic [1:0] boot_select;
      logic       first_cs_width;
      logic [4:0] ext_addr_width;
      logic       dsp_self_boot;
   } straps_t;

   typedef struct packed {
      logic [4:0] setup;
      logic [6:0] strobe;
      logic [3:0] hold;
   } wait_states_t;

   typedef struct packed {
      logic dma;
      logic ext_mem;
      logic uart;
      logic dsp;
   } clk_en_t;

endpackage

// File: design/boot_strap_config_latch.sv
`timescale 1ns/1ps
// What this block does
// - capture all straps as reset ends and hold them as the settings
// - capture happens on the rising edge of active-low global reset
// - after capture the shared pins switch to video output function
// - boot select: 00 ROM nand/spi, 01 ext memory, 10 reserved, 11 ROM uart
// - uart boot, or primary boot failure, sets the uart pin route bit
// - nand boot makes the first chip-select region a nand interface
// - codes 00, 10, 11 force first fetch to jump to ROM 0000_4000
// - code 01 forces first fetch to jump to 0200_0000, default timings
// - width strap: 0 gives 8-bit, 1 gives 16-bit first region
// - all other chip-select regions default to 8-bit until software changes
// - software may change the first region width after boot
// - five-bit address-width strap loads the pin-mux address-width field
// - by default all address pins are general purpose except bits 1 and 2
// - wait states reset to 16 setup, 64 strobe, 8 hold cycles
// - after reset the PLLs are bypassed and disabled
// - default module clock enables follow the captured straps
// - dsp self-boot 0: dsp stays powered off and held in reset
// - dsp self-boot 1: dsp powered, released, boots 4220_0000 with icache
module boot_strap_config_latch
   import strap_cfg_pkg::*;
#(
   parameter int ADDR_PINS = NUM_ADDR_PINS,
   parameter int CS_COUNT  = NUM_CS
) (
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 global_reset_n,
   // shared strap / video pins
   input  wire logic [1:0]           boot_select_strap,
   input  wire logic                 first_cs_width_strap,
   input  wire logic                 dsp_self_boot_strap,
   input  wire logic [4:0]           ext_addr_width_strap,
   output logic                      video_pins_active,
   // fetch logic
   input  wire logic                 first_fetch,
   output logic                      force_jump,
   output logic [31:0]               jump_target,
   // primary boot failure from the loader
   input  wire logic                 boot_failed,
   // software width write for the first region
   input  wire logic                 sw_width_wr,
   input  wire logic                 sw_width_val,
   // external memory controller defaults
   output logic                      first_cs_is_nand,
   output logic [CS_COUNT-1:0]       cs_width_16,
   output wait_states_t              wait_states,
   // pin multiplexing
   output logic                      uart_pin_route_bit,
   output logic [4:0]                addr_pin_count_field,
   output logic [ADDR_PINS-1:0]      addr_pin_gp,
   // power, clocks and dsp
   output logic                      pll_bypass,
   output logic                      pll_enable,
   output clk_en_t                   clk_en,
   output logic                      dsp_power_on,
   output logic                      dsp_reset_release,
   output logic                      dsp_icache_en,
   output logic [31:0]               dsp_boot_address,
   output straps_t                   boot_config_capture
);

   straps_t       strap_q;
   logic          gr_n_q;
   logic          fetched_q;
   logic          in_reset_q;
   logic          cs0_width_q;
   logic          uart_route_q;
   logic          force_q;
   logic [31:0]   target_q;

   // sampled pins assembled into one strap word
   straps_t       pins_now;
   wire logic     reset_rise;
   wire logic     rom_boot;
   wire logic [31:0] entry_addr;
   wire logic     settled;
   wire logic     nand_boot;
   wire logic     uart_boot;
   wire logic     dsp_self;
   wire logic     addr_all_gp;

   assign pins_now = '{boot_select:    boot_select_strap,
                       first_cs_width: first_cs_width_strap,
                       ext_addr_width: ext_addr_width_strap,
                       dsp_self_boot:  dsp_self_boot_strap};
   assign reset_rise = global_reset_n & ~gr_n_q;
   // code 10 has no loader behind it in this block, so it is treated as a rom boot
   assign rom_boot   = (strap_q.boot_select != BOOT_EXT_MEM);
   assign settled     = !in_reset_q;
   assign nand_boot   = (strap_q.boot_select == BOOT_ROM_NAND);
   assign uart_boot   = (strap_q.boot_select == BOOT_ROM_UART);
   assign dsp_self    = strap_q.dsp_self_boot;
   assign addr_all_gp = (strap_q.ext_addr_width == ADDR_WIDTH_RST);
   assign entry_addr = rom_boot ? ROM_ENTRY_ADDR : EXT_ENTRY_ADDR;

   // edge detector on the reset pin; pin is treated as synchronous
   always_ff @(posedge mclk) begin
      if (rst) begin
         gr_n_q <= 1'h0;
      end else begin
         gr_n_q <= global_reset_n;
      end
   end

   // straps only move on the reset release edge, never on later pin traffic
   always_ff @(posedge mclk) begin
      if (rst) begin
         strap_q <= '{BOOT_SEL_RST, CS_WIDTH_RST, ADDR_WIDTH_RST, DSP_BOOT_RST};
      end else if (reset_rise) begin
         strap_q <= pins_now;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         in_reset_q <= 1'h1;
      end else if (!global_reset_n) begin
         in_reset_q <= 1'h1;
      end else if (reset_rise) begin
         in_reset_q <= 1'h0;
      end
   end

   // first fetch after release gets the forced jump, once only
   always_ff @(posedge mclk) begin
      if (rst || !global_reset_n) begin
         fetched_q <= 1'h0;
      end else if (first_fetch && !in_reset_q) begin
         fetched_q <= 1'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || !global_reset_n) begin
         force_q  <= 1'h0;
         target_q <= ROM_ENTRY_ADDR;
      end else begin
         force_q  <= first_fetch && !in_reset_q && !fetched_q;
         target_q <= entry_addr;
      end
   end

   // width reloads from strap on each capture, software may override after
   always_ff @(posedge mclk) begin
      if (rst) begin
         cs0_width_q <= CS_WIDTH_RST;
      end else if (reset_rise) begin
         cs0_width_q <= pins_now.first_cs_width;
      end else if (sw_width_wr && !in_reset_q) begin
         cs0_width_q <= sw_width_val;
      end
   end

   // failure fallback to uart is sticky until next reset
   always_ff @(posedge mclk) begin
      if (rst || !global_reset_n) begin
         uart_route_q <= 1'h0;
      end else if (reset_rise) begin
         uart_route_q <= (pins_now.boot_select == BOOT_ROM_UART);
      end else if (boot_failed) begin
         uart_route_q <= 1'h1;
      end
   end

   // boot and fetch outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         video_pins_active <= 1'h0;
         force_jump        <= 1'h0;
         jump_target       <= ROM_ENTRY_ADDR;
      end else begin
         video_pins_active <= settled && global_reset_n;
         force_jump        <= force_q;
         jump_target       <= target_q;
      end
   end

   a_jump_once: assert property (@(posedge mclk) disable iff (rst)
      force_jump |=> !force_jump)
      else $error("forced jump lasted more than one cycle");

   a_video_off: assert property (@(posedge mclk) disable iff (rst)
      !global_reset_n |=> !video_pins_active)
      else $error("video pins active while reset held");

   // memory controller defaults; the wait states are only reset values, the
   // controller's own registers take over once software writes them
   always_ff @(posedge mclk) begin
      if (rst) begin
         first_cs_is_nand <= 1'h0;
         cs_width_16      <= '0;
         wait_states      <= '{SETUP_CYC_RST, STROBE_CYC_RST, HOLD_CYC_RST};
      end else begin
         first_cs_is_nand <= settled && nand_boot;
         cs_width_16      <= {{(CS_COUNT-1){1'h0}}, cs0_width_q};
         wait_states      <= '{SETUP_CYC_RST, STROBE_CYC_RST, HOLD_CYC_RST};
      end
   end

   a_nand_region: assert property (@(posedge mclk) disable iff (rst)
      settled |=> first_cs_is_nand == $past(nand_boot))
      else $error("first region nand setting wrong");

   a_first_width: assert property (@(posedge mclk) disable iff (rst)
      reset_rise |=> cs0_width_q == $past(pins_now.first_cs_width))
      else $error("first region width not taken from strap");

   a_sw_width: assert property (@(posedge mclk) disable iff (rst)
      sw_width_wr && settled |=> cs0_width_q == $past(sw_width_val))
      else $error("software width write lost");

   // pin multiplexing
   always_ff @(posedge mclk) begin
      if (rst) begin
         uart_pin_route_bit   <= 1'h0;
         addr_pin_count_field <= ADDR_WIDTH_RST;
      end else begin
         uart_pin_route_bit   <= uart_route_q;
         addr_pin_count_field <= strap_q.ext_addr_width;
      end
   end

   a_route_capture: assert property (@(posedge mclk) disable iff (rst)
      reset_rise |=> uart_route_q == ($past(pins_now.boot_select) == BOOT_ROM_UART))
      else $error("uart route not taken from boot select");

   a_count_field: assert property (@(posedge mclk) disable iff (rst)
      1'h1 |=> addr_pin_count_field == $past(strap_q.ext_addr_width))
      else $error("address width field differs from strap");

   // plls stay bypassed: the reference clock drives everything until software
   // programs them, so nothing here waits on a lock indication
   always_ff @(posedge mclk) begin
      if (rst) begin
         pll_bypass <= 1'h1;
         pll_enable <= 1'h0;
         clk_en     <= '0;
      end else begin
         pll_bypass     <= 1'h1;
         pll_enable     <= 1'h0;
         clk_en.dma     <= settled && rom_boot;
         clk_en.ext_mem <= settled;
         clk_en.uart    <= settled && uart_boot;
         clk_en.dsp     <= settled && dsp_self;
      end
   end

   a_uart_clock: assert property (@(posedge mclk) disable iff (rst)
      settled |=> clk_en.uart == $past(uart_boot))
      else $error("uart clock enable wrong");

   a_mem_clock: assert property (@(posedge mclk) disable iff (rst)
      settled |=> clk_en.ext_mem)
      else $error("memory clock off after capture");

   // the dsp comes up on its own only with the self-boot strap
   always_ff @(posedge mclk) begin
      if (rst) begin
         dsp_power_on        <= 1'h0;
         dsp_reset_release   <= 1'h0;
         dsp_icache_en       <= 1'h0;
         dsp_boot_address    <= DSP_BOOT_ADDR;
         boot_config_capture <= '0;
      end else begin
         dsp_power_on        <= settled && dsp_self;
         dsp_reset_release   <= settled && dsp_self;
         dsp_icache_en       <= settled && dsp_self;
         dsp_boot_address    <= DSP_BOOT_ADDR;
         boot_config_capture <= strap_q;
      end
   end

   a_dsp_release: assert property (@(posedge mclk) disable iff (rst)
      settled && dsp_self |=> dsp_power_on && dsp_reset_release && dsp_icache_en)
      else $error("self-booting dsp not released");

   a_config_copy: assert property (@(posedge mclk) disable iff (rst)
      1'h1 |=> boot_config_capture == $past(strap_q))
      else $error("captured configuration not shown");

   // address pins: general purpose by default except bits 1 and 2
   genvar gi;
   generate
      for (gi = 0; gi < ADDR_PINS; gi++) begin : g_addr
         always_ff @(posedge mclk) begin
            if (rst) begin
               addr_pin_gp[gi] <= ADDR_GP_RST[gi];
            end else begin
               // a zero strap leaves every pin but 1 and 2 general purpose
               addr_pin_gp[gi] <= (gi != 1) && (gi != 2)
                                  && (addr_all_gp
                                      || (gi >= 3 + 32'(strap_q.ext_addr_width)));
            end
         end
      end
   endgenerate

   a_addr_default: assert property (@(posedge mclk) disable iff (rst)
      addr_all_gp |=> addr_pin_gp == ADDR_GP_RST)
      else $error("default address pin use wrong");

   a_addr_fixed: assert property (@(posedge mclk) disable iff (rst)
      addr_pin_gp[2:1] == 2'h0)
      else $error("nand latch pins given to general use");

   // assertions
   a_straps_hold: assert property (@(posedge mclk) disable iff (rst)
      !reset_rise |=> $stable(strap_q))
      else $error("straps changed without reset release");
   a_capture_edge: assert property (@(posedge mclk) disable iff (rst)
      reset_rise |=> strap_q == $past(pins_now))
      else $error("straps not captured at release");
   a_rise_only: assert property (@(posedge mclk) disable iff (rst)
      $rose(global_reset_n) |-> reset_rise)
      else $error("release edge missed");
   a_video_switch: assert property (@(posedge mclk) disable iff (rst)
      reset_rise ##1 global_reset_n |=> video_pins_active)
      else $error("video pins not active after capture");
   a_jump_target: assert property (@(posedge mclk) disable iff (rst)
      force_jump |-> jump_target == ((strap_q.boot_select == BOOT_EXT_MEM)
                                     ? EXT_ENTRY_ADDR : ROM_ENTRY_ADDR))
      else $error("wrong boot target");
   a_uart_route: assert property (@(posedge mclk) disable iff (rst || !global_reset_n)
      boot_failed && !reset_rise |-> ##2 uart_pin_route_bit)
      else $error("uart route not set after failure");
   a_wait_slow: assert property (@(posedge mclk) disable iff (rst)
      wait_states.setup == 5'h10 && wait_states.strobe == 7'h40
      && wait_states.hold == 4'h8)
      else $error("wait states not slowest");
   a_pll_bypass: assert property (@(posedge mclk) disable iff (rst)
      pll_bypass && !pll_enable)
      else $error("pll not bypassed");
   a_dsp_off: assert property (@(posedge mclk) disable iff (rst)
      !strap_q.dsp_self_boot ##1 !strap_q.dsp_self_boot |-> !dsp_power_on)
      else $error("dsp powered without self boot");
   a_cs_others: assert property (@(posedge mclk) disable iff (rst)
      cs_width_16[CS_COUNT-1:1] == '0)
      else $error("other chip selects not 8-bit");

endmodule // boot_strap_config_latch

// File: test/strap_board.sv
`timescale 1ns/1ps
module strap_board
   import strap_cfg_pkg::*;
(
   // clock
   input  wire logic       mclk,
   // bench control
   input  wire logic       hold_reset,
   input  wire straps_t    strap_set,
   input  wire logic       video_pins_active,
   // device pins
   output logic            global_reset_n,
   output logic [1:0]      boot_select_strap,
   output logic            first_cs_width_strap,
   output logic            dsp_self_boot_strap,
   output logic [4:0]      ext_addr_width_strap
);
   logic       video_q;
   logic [8:0] pat_q;
   logic [8:0] pins;

   assign global_reset_n = ~hold_reset;
   // resistors show only while sampling; later the pins carry moving video data
   assign pins = video_q ? pat_q : strap_set;
   assign {boot_select_strap, first_cs_width_strap,
           ext_addr_width_strap, dsp_self_boot_strap} = pins;
   always @(posedge mclk) begin
      video_q <= video_pins_active & global_reset_n;
      pat_q   <= ~pins;
   end
endmodule // strap_board

// File: test/test_boot_strap_config_latch.sv
`timescale 1ns/1ps
module test_boot_strap_config_latch;
   import strap_cfg_pkg::*;
   logic         mclk, rst, hold_reset, global_reset_n, first_cs_width_strap, dsp_self_boot_strap;
   logic         first_fetch, boot_failed, sw_width_wr, sw_width_val;
   logic         video_pins_active, force_jump, first_cs_is_nand, uart_pin_route_bit;
   logic         pll_bypass, pll_enable, dsp_power_on, dsp_reset_release, dsp_icache_en;
   logic [1:0]   boot_select_strap;
   logic [4:0]   ext_addr_width_strap, addr_pin_count_field;
   logic [3:0]   cs_width_16;
   logic [21:0]  addr_pin_gp;
   logic [31:0]  jump_target, dsp_boot_address;
   wait_states_t wait_states;
   clk_en_t      clk_en;
   straps_t      strap_set, boot_config_capture;
   int           fail_count, cmp_count, cycles;

   strap_board board (.mclk(mclk), .hold_reset(hold_reset), .strap_set(strap_set),
      .video_pins_active(video_pins_active), .global_reset_n(global_reset_n),
      .boot_select_strap(boot_select_strap), .first_cs_width_strap(first_cs_width_strap),
      .dsp_self_boot_strap(dsp_self_boot_strap), .ext_addr_width_strap(ext_addr_width_strap));

   boot_strap_config_latch DUT (.mclk(mclk), .rst(rst), .global_reset_n(global_reset_n),
      .boot_select_strap(boot_select_strap), .first_cs_width_strap(first_cs_width_strap),
      .dsp_self_boot_strap(dsp_self_boot_strap), .ext_addr_width_strap(ext_addr_width_strap),
      .video_pins_active(video_pins_active),
      .first_fetch(first_fetch), .force_jump(force_jump), .jump_target(jump_target),
      .boot_failed(boot_failed), .sw_width_wr(sw_width_wr), .sw_width_val(sw_width_val),
      .first_cs_is_nand(first_cs_is_nand), .cs_width_16(cs_width_16),
      .wait_states(wait_states), .uart_pin_route_bit(uart_pin_route_bit),
      .addr_pin_count_field(addr_pin_count_field), .addr_pin_gp(addr_pin_gp),
      .pll_bypass(pll_bypass), .pll_enable(pll_enable), .clk_en(clk_en),
      .dsp_power_on(dsp_power_on), .dsp_reset_release(dsp_reset_release),
      .dsp_icache_en(dsp_icache_en), .dsp_boot_address(dsp_boot_address),
      .boot_config_capture(boot_config_capture));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // hang guard: a full run needs well under 300 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         $display("Error at %0t: timeout", $time);
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic fetch();
      first_fetch = 1'b1;
      cyc(1);
      first_fetch = 1'b0;
      // force_jump stands one cycle, two edges after the request: look right then
      cyc(1);
   endtask

   task automatic boot(input straps_t s);
      logic [1:0] c;
      c = s.boot_select;
      hold_reset = 1'b1;
      strap_set = s;
      cyc(3);
      hold_reset = 1'b0;
      cyc(4);
      chk(boot_config_capture, s);
      chk(video_pins_active, 1);
      chk(uart_pin_route_bit, c == BOOT_ROM_UART);
      chk(first_cs_is_nand, c == BOOT_ROM_NAND);
      chk(cs_width_16, {3'h0, s.first_cs_width});
      chk(addr_pin_count_field, s.ext_addr_width);
      chk(wait_states, {SETUP_CYC_RST, STROBE_CYC_RST, HOLD_CYC_RST});
      chk({pll_bypass, pll_enable}, 2'h2);
      chk(clk_en.uart, c == BOOT_ROM_UART);
      chk(clk_en, {c != BOOT_EXT_MEM, 1'h1, c == BOOT_ROM_UART, s.dsp_self_boot});
      chk(addr_pin_gp[2:1], 2'h0);
      if (s.ext_addr_width == 5'h00) chk(addr_pin_gp, ADDR_GP_RST);
      if (s.ext_addr_width == 5'h0A) chk(addr_pin_gp, 22'h3FE000);
      chk({dsp_power_on, dsp_reset_release}, {2{s.dsp_self_boot}});
      chk(dsp_icache_en, s.dsp_self_boot);
      chk(dsp_boot_address, DSP_BOOT_ADDR);
      fetch();
      chk(force_jump, 1);
      chk(jump_target, c == BOOT_EXT_MEM ? EXT_ENTRY_ADDR : ROM_ENTRY_ADDR);
      cyc(1);
      chk(force_jump, 0);
      // a second fetch in the same boot must not jump again
      fetch();
      chk(force_jump, 0);
      sw_width_wr = 1'b1;
      sw_width_val = ~s.first_cs_width;
      cyc(1);
      sw_width_wr = 1'b0;
      cyc(2);
      chk(cs_width_16, {3'h0, ~s.first_cs_width});
      if (c == BOOT_ROM_NAND) begin
         boot_failed = 1'b1;
         cyc(1);
         boot_failed = 1'b0;
         cyc(2);
         chk(uart_pin_route_bit, 1);
      end
      chk(boot_config_capture, s);
      $display("test boot code %0d done", c);
   endtask

   initial begin
      rst = 1'b1;
      hold_reset = 1'b1;
      strap_set = '0;
      first_fetch = 1'b0;
      boot_failed = 1'b0;
      sw_width_wr = 1'b0;
      sw_width_val = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      cycles = 0;
      cyc(2);
      rst = 1'b0;
      cyc(1);
      chk(addr_pin_gp, ADDR_GP_RST);
      chk({pll_bypass, pll_enable}, 2'h2);
      $display("test reset defaults done");
      // dsp self-boot never paired with the nand code
      boot('{BOOT_ROM_NAND, 1'b1, 5'h00, 1'b0});
      boot('{BOOT_EXT_MEM, 1'b0, 5'h15, 1'b1});
      boot('{BOOT_RSVD, 1'b1, 5'h1F, 1'b1});
      boot('{BOOT_ROM_UART, 1'b0, 5'h0A, 1'b0});
      end_sim();
   end
endmodule // test_boot_strap_config_latch
